/* include/clrdec_pkg.sv */
/*
 * Shared constants, types and the opcode decoder for the clear/decrement/branch
 * execution block. Assumes 14-bit instruction words, 8-bit data, 13-bit program
 * counter and a 32-bit AHB-Lite register port.
 */
package clrdec_pkg;

    // datapath widths
    localparam int DATA_W   = 8;
    localparam int PC_W     = 13;
    localparam int INSTR_W  = 14;
    localparam int FILE_AW  = 7;
    localparam int FILE_N   = 128;
    localparam int JUMP_K_W = 11;
    localparam int BUS_AW   = 8;

    // instruction and upper-latch field positions
    localparam int DEST_BIT   = 7;
    localparam int PCU_HI_BIT = 4;
    localparam int PCU_LO_BIT = 3;

    // opcode masks and match values
    localparam logic [INSTR_W-1:0] OPC_CLRACC_MASK = 14'h3F80;
    localparam logic [INSTR_W-1:0] OPC_CLRACC_VAL  = 14'h0100;
    localparam logic [INSTR_W-1:0] OPC_KICK_VAL    = 14'h0064;
    localparam logic [INSTR_W-1:0] OPC_FILE_MASK   = 14'h3F00;
    localparam logic [INSTR_W-1:0] OPC_COMP_VAL    = 14'h0900;
    localparam logic [INSTR_W-1:0] OPC_DEC_VAL     = 14'h0300;
    localparam logic [INSTR_W-1:0] OPC_DECSKIP_VAL = 14'h0B00;
    localparam logic [INSTR_W-1:0] OPC_JUMP_MASK   = 14'h3800;
    localparam logic [INSTR_W-1:0] OPC_JUMP_VAL    = 14'h2800;
    localparam logic [INSTR_W-1:0] OPC_IDLE_WORD   = 14'h0000;

    // register byte offsets
    localparam logic [BUS_AW-1:0] OFS_CTRL      = 8'h00;
    localparam logic [BUS_AW-1:0] OFS_STATUS    = 8'h04;
    localparam logic [BUS_AW-1:0] OFS_ACC       = 8'h08;
    localparam logic [BUS_AW-1:0] OFS_PC        = 8'h0C;
    localparam logic [BUS_AW-1:0] OFS_PCU       = 8'h10;
    localparam logic [BUS_AW-1:0] OFS_WDT_CNT   = 8'h14;
    localparam logic [BUS_AW-1:0] OFS_WDT_PRE   = 8'h18;
    localparam logic [BUS_AW-1:0] OFS_FILE_ADDR = 8'h1C;
    localparam logic [BUS_AW-1:0] OFS_FILE_DATA = 8'h20;
    localparam logic [BUS_AW-1:0] OFS_INSTR     = 8'h24;

    // register field positions
    localparam int CTRL_RUN_BIT   = 0;
    localparam int ST_ZERO_BIT    = 0;
    localparam int ST_SLEEP_N_BIT = 1;
    localparam int ST_EXPIRY_N_BIT = 2;

    // reset values
    localparam logic [PC_W-1:0]   PC_RST  = 13'h0000;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] PCU_RST = 8'h00;

    // default phase divider: one core clock per phase
    localparam int PHASE_DIV_DEF = 1;

    typedef enum logic [1:0] {
        CLRDEC_Q1,
        CLRDEC_Q2,
        CLRDEC_Q3,
        CLRDEC_Q4
    } clrdec_qphase_t;

    typedef enum logic [2:0] {
        CLRDEC_OP_NONE,
        CLRDEC_OP_CLRACC,
        CLRDEC_OP_KICK,
        CLRDEC_OP_COMP,
        CLRDEC_OP_DEC,
        CLRDEC_OP_DECSKIP,
        CLRDEC_OP_JUMP
    } clrdec_op_t;

    typedef struct packed {
        logic expiryFlagN;
        logic sleepFlagN;
        logic resultNullFlag;
    } clrdec_status_t;

    localparam clrdec_status_t STATUS_RST = '{expiryFlagN: 1'b1, sleepFlagN: 1'b1, resultNullFlag: 1'b0};

    // opcode classification; anything unknown runs as an idle cycle
    function automatic clrdec_op_t clrdec_decode(input logic [INSTR_W-1:0] word);
        clrdec_op_t op;
        op = CLRDEC_OP_NONE;
        if ((word & OPC_CLRACC_MASK) == OPC_CLRACC_VAL)
            op = CLRDEC_OP_CLRACC;
        else if (word == OPC_KICK_VAL)
            op = CLRDEC_OP_KICK;
        else if ((word & OPC_FILE_MASK) == OPC_COMP_VAL)
            op = CLRDEC_OP_COMP;
        else if ((word & OPC_FILE_MASK) == OPC_DEC_VAL)
            op = CLRDEC_OP_DEC;
        else if ((word & OPC_FILE_MASK) == OPC_DECSKIP_VAL)
            op = CLRDEC_OP_DECSKIP;
        else if ((word & OPC_JUMP_MASK) == OPC_JUMP_VAL)
            op = CLRDEC_OP_JUMP;
        return op;
    endfunction

endpackage

/* src/clrdec_exec.sv */
/*
 * Decode and execute for six instructions of an 8-bit core, with the file
 * registers, accumulator, status, program counter and watchdog counters it
 * touches, all visible over an AHB-Lite slave. Assumes program memory answers
 * progAddr combinationally on progData within the same core_clk cycle.
 *
 */
`timescale 1ns/100ps
module clrdec_exec #(
    parameter int PHASE_DIV = clrdec_pkg::PHASE_DIV_DEF,
    parameter int WDT_W     = 8,
    parameter int PRESC_W   = 8
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst_b,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic      [clrdec_pkg::PC_W-1:0]   progAddr,
    input  wire logic [clrdec_pkg::INSTR_W-1:0] progData
);
    import clrdec_pkg::*;

    // core state
    logic [PC_W-1:0]    pc_reg,       pc_next;
    logic [DATA_W-1:0]  acc_reg,      acc_next;
    logic [DATA_W-1:0]  pcUpper_reg,  pcUpper_next;
    logic [INSTR_W-1:0] instr_reg,    instr_next;
    logic [DATA_W-1:0]  operand_reg,  operand_next;
    logic [DATA_W-1:0]  result_reg,   result_next;
    logic               skipPend_reg, skipPend_next;
    logic               jumpPend_reg, jumpPend_next;
    logic               run_reg,      run_next;
    logic [FILE_AW-1:0] fileSel_reg,  fileSel_next;
    logic [WDT_W-1:0]   wdtCnt_reg,   wdtCnt_next;
    logic [PRESC_W-1:0] wdtPre_reg,   wdtPre_next;
    clrdec_status_t     status_reg,   status_next;

    // bus data-phase state
    logic               dpValid_reg,  dpValid_next;
    logic               dpWrite_reg,  dpWrite_next;
    logic [BUS_AW-1:0]  dpAddr_reg,   dpAddr_next;
    logic [31:0]        hrdata_reg,   hrdata_next;

    // file register array
    logic [DATA_W-1:0]  fileMem [0:FILE_N-1];
    logic               fileWe;
    logic [FILE_AW-1:0] fileWAddr;
    logic [DATA_W-1:0]  fileWData;

    clrdec_qphase_t     phase;
    logic               phaseEn;
    clrdec_op_t         curOp;
    logic               destFile;
    logic [FILE_AW-1:0] fAddr;
    logic               fileOp;
    logic               addrPhase;
    logic               addrHit;
    logic               busWr;

    clrdec_qseq #(
        .PHASE_DIV (PHASE_DIV)
    ) u_qseq (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .run      (run_reg),
        .phase    (phase),
        .phaseEn  (phaseEn)
    );

    // operand fields of the latched word
    assign curOp    = clrdec_decode(instr_reg);
    assign destFile = instr_reg[DEST_BIT];
    assign fAddr    = instr_reg[FILE_AW-1:0];
    assign fileOp   = (curOp == CLRDEC_OP_COMP) || (curOp == CLRDEC_OP_DEC) || (curOp == CLRDEC_OP_DECSKIP);

    // bus decode; only word accesses are expected, hsize is not checked
    assign addrPhase = hsel && hready && htrans[1];
    assign addrHit   = (haddr[31:BUS_AW] == '0) && (haddr[1:0] == 2'b00);
    assign busWr     = dpValid_reg && dpWrite_reg;

    // execution: bus writes first, then the phase work, so the core wins a clash
    always_comb begin
        pc_next       = pc_reg;
        acc_next      = acc_reg;
        pcUpper_next  = pcUpper_reg;
        instr_next    = instr_reg;
        operand_next  = operand_reg;
        result_next   = result_reg;
        skipPend_next = skipPend_reg;
        jumpPend_next = jumpPend_reg;
        run_next      = run_reg;
        fileSel_next  = fileSel_reg;
        wdtCnt_next   = wdtCnt_reg;
        wdtPre_next   = wdtPre_reg;
        status_next   = status_reg;
        fileWe        = 1'b0;
        fileWAddr     = fAddr;
        fileWData     = result_reg;

        if (busWr) begin
            unique case (dpAddr_reg)
                OFS_CTRL:      run_next = hwdata[CTRL_RUN_BIT];
                OFS_STATUS: begin
                    status_next.resultNullFlag = hwdata[ST_ZERO_BIT];
                    status_next.sleepFlagN     = hwdata[ST_SLEEP_N_BIT];
                    status_next.expiryFlagN    = hwdata[ST_EXPIRY_N_BIT];
                end
                OFS_ACC:       acc_next     = hwdata[DATA_W-1:0];
                OFS_PC:        pc_next      = hwdata[PC_W-1:0];
                OFS_PCU:       pcUpper_next = hwdata[DATA_W-1:0];
                OFS_FILE_ADDR: fileSel_next = hwdata[FILE_AW-1:0];
                OFS_FILE_DATA: begin
                    fileWe    = 1'b1;
                    fileWAddr = fileSel_reg;
                    fileWData = hwdata[DATA_W-1:0];
                end
                default: ;
            endcase
        end

        if (phaseEn) begin
            unique case (phase)
                // Q1: fetch; an idle cycle replaces the word after a jump or taken skip
                CLRDEC_Q1: begin
                    if (jumpPend_reg) begin
                        instr_next    = OPC_IDLE_WORD;
                        jumpPend_next = 1'b0;
                    end else if (skipPend_reg) begin
                        instr_next    = OPC_IDLE_WORD;
                        skipPend_next = 1'b0;
                        pc_next       = pc_reg + 1'b1;
                    end else begin
                        instr_next = progData;
                        pc_next    = pc_reg + 1'b1;
                    end
                end
                // Q2: read the file operand
                CLRDEC_Q2: begin
                    if (fileOp)
                        operand_next = fileMem[fAddr];
                end
                // Q3: process
                CLRDEC_Q3: begin
                    unique case (curOp)
                        CLRDEC_OP_COMP:    result_next = ~operand_reg;
                        CLRDEC_OP_DEC,
                        CLRDEC_OP_DECSKIP: result_next = operand_reg - 1'b1;
                        CLRDEC_OP_CLRACC:  result_next = '0;
                        default:           result_next = result_reg;
                    endcase
                end
                // Q4: write destination, flags, program counter and watchdog
                CLRDEC_Q4: begin
                    {wdtCnt_next, wdtPre_next} = {wdtCnt_reg, wdtPre_reg} + 1'b1;
                    unique case (curOp)
                        CLRDEC_OP_CLRACC: begin
                            acc_next                   = '0;
                            status_next.resultNullFlag = 1'b1;
                        end
                        CLRDEC_OP_KICK: begin
                            wdtCnt_next             = '0;
                            wdtPre_next             = '0;
                            status_next.expiryFlagN = 1'b1;
                            status_next.sleepFlagN  = 1'b1;
                        end
                        CLRDEC_OP_COMP,
                        CLRDEC_OP_DEC: begin
                            if (destFile) begin
                                fileWe    = 1'b1;
                                fileWAddr = fAddr;
                                fileWData = result_reg;
                            end else begin
                                acc_next = result_reg;
                            end
                            status_next.resultNullFlag = (result_reg == '0);
                        end
                        CLRDEC_OP_DECSKIP: begin
                            if (destFile) begin
                                fileWe    = 1'b1;
                                fileWAddr = fAddr;
                                fileWData = result_reg;
                            end else begin
                                acc_next = result_reg;
                            end
                            if (result_reg == '0)
                                skipPend_next = 1'b1;
                        end
                        CLRDEC_OP_JUMP: begin
                            pc_next = {pcUpper_reg[PCU_HI_BIT:PCU_LO_BIT],
                                       instr_reg[JUMP_K_W-1:0]};
                            jumpPend_next = 1'b1;
                        end
                        default: ;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_reg       <= PC_RST;
            acc_reg      <= ACC_RST;
            pcUpper_reg  <= PCU_RST;
            instr_reg    <= OPC_IDLE_WORD;
            operand_reg  <= '0;
            result_reg   <= '0;
            skipPend_reg <= 1'b0;
            jumpPend_reg <= 1'b0;
            run_reg      <= 1'b0;
            fileSel_reg  <= '0;
            wdtCnt_reg   <= '0;
            wdtPre_reg   <= '0;
            status_reg   <= STATUS_RST;
        end else begin
            pc_reg       <= pc_next;
            acc_reg      <= acc_next;
            pcUpper_reg  <= pcUpper_next;
            instr_reg    <= instr_next;
            operand_reg  <= operand_next;
            result_reg   <= result_next;
            skipPend_reg <= skipPend_next;
            jumpPend_reg <= jumpPend_next;
            run_reg      <= run_next;
            fileSel_reg  <= fileSel_next;
            wdtCnt_reg   <= wdtCnt_next;
            wdtPre_reg   <= wdtPre_next;
            status_reg   <= status_next;
        end
    end

    // file storage has no reset, software must initialise what it uses
    always_ff @(posedge core_clk) begin
        if (fileWe)
            fileMem[fileWAddr] <= fileWData;
    end

    // bus slave: zero wait states, read data registered at the address phase
    always_comb begin
        dpValid_next = addrPhase && addrHit;
        dpWrite_next = addrPhase && hwrite;
        dpAddr_next  = addrPhase ? haddr[BUS_AW-1:0] : dpAddr_reg;
        hrdata_next  = hrdata_reg;
        if (addrPhase && !hwrite) begin
            hrdata_next = '0;
            if (addrHit) begin
                unique case (haddr[BUS_AW-1:0])
                    OFS_CTRL:      hrdata_next[CTRL_RUN_BIT] = run_reg;
                    OFS_STATUS: begin
                        hrdata_next[ST_ZERO_BIT]     = status_reg.resultNullFlag;
                        hrdata_next[ST_SLEEP_N_BIT]  = status_reg.sleepFlagN;
                        hrdata_next[ST_EXPIRY_N_BIT] = status_reg.expiryFlagN;
                    end
                    OFS_ACC:       hrdata_next[DATA_W-1:0]  = acc_reg;
                    OFS_PC:        hrdata_next[PC_W-1:0]    = pc_reg;
                    OFS_PCU:       hrdata_next[DATA_W-1:0]  = pcUpper_reg;
                    OFS_WDT_CNT:   hrdata_next[WDT_W-1:0]   = wdtCnt_reg;
                    OFS_WDT_PRE:   hrdata_next[PRESC_W-1:0] = wdtPre_reg;
                    OFS_FILE_ADDR: hrdata_next[FILE_AW-1:0] = fileSel_reg;
                    OFS_FILE_DATA: hrdata_next[DATA_W-1:0]  = fileMem[fileSel_reg];
                    OFS_INSTR:     hrdata_next[INSTR_W-1:0] = instr_reg;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dpValid_reg <= 1'b0;
            dpWrite_reg <= 1'b0;
            dpAddr_reg  <= '0;
            hrdata_reg  <= '0;
        end else begin
            dpValid_reg <= dpValid_next;
            dpWrite_reg <= dpWrite_next;
            dpAddr_reg  <= dpAddr_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;        // never stalls
    assign hresp     = 1'b0;        // always OKAY
    assign progAddr  = pc_reg;

endmodule

/* src/clrdec_qseq.sv */
/*
 * Four-phase sequencer: steps Q1..Q4 on a one-cycle enable from a divider.
 * Assumes the run level comes from logic on core_clk.
 */
`timescale 1ns/100ps
module clrdec_qseq #(
    parameter int PHASE_DIV = clrdec_pkg::PHASE_DIV_DEF
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic                       run,
    output clrdec_pkg::clrdec_qphase_t      phase,
    output logic                            phaseEn
);
    import clrdec_pkg::*;

    localparam int CNT_W = (PHASE_DIV > 1) ? $clog2(PHASE_DIV) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PHASE_DIV - 1);

    logic [CNT_W-1:0] divCnt_reg;
    logic [CNT_W-1:0] divCnt_next;
    clrdec_qphase_t   phase_reg;
    clrdec_qphase_t   phase_next;

    // stopping parks at Q1 so a restart always begins a fresh cycle
    always_comb begin
        divCnt_next = divCnt_reg;
        phase_next  = phase_reg;
        phaseEn     = 1'b0;
        if (!run) begin
            divCnt_next = '0;
            phase_next  = CLRDEC_Q1;
        end else if (divCnt_reg == CNT_LAST) begin
            divCnt_next = '0;
            phaseEn     = 1'b1;
            unique case (phase_reg)
                CLRDEC_Q1: phase_next = CLRDEC_Q2;
                CLRDEC_Q2: phase_next = CLRDEC_Q3;
                CLRDEC_Q3: phase_next = CLRDEC_Q4;
                CLRDEC_Q4: phase_next = CLRDEC_Q1;
            endcase
        end else begin
            divCnt_next = divCnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_reg <= '0;
            phase_reg  <= CLRDEC_Q1;
        end else begin
            divCnt_reg <= divCnt_next;
            phase_reg  <= phase_next;
        end
    end

    assign phase = phase_reg;

endmodule

/* test/clear_dec_branch_instr_exec_tb.sv */
/*
 * Self-checking bench: registers set over the bus, short programs run, results read back.
 * Assumes the program memory model and the bound checker.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
end
module clear_dec_branch_instr_exec_tb;
    import clrdec_pkg::*;
    logic               core_clk = 1'b0;
    logic               rst_b    = 1'b0;
    logic               hsel     = 1'b0;
    logic               hwrite   = 1'b0;
    logic [1:0]         htrans   = 2'b00;
    logic [31:0]        haddr    = '0;
    logic [31:0]        hwdata   = '0;
    logic [31:0]        hrdata;
    logic [31:0]        rdData;
    logic               hreadyout;
    logic               hresp;
    logic [PC_W-1:0]    progAddr;
    logic [INSTR_W-1:0] progData;
    int                 fail_count = 0;
    int                 num_checks = 0;
    int                 cycles     = 0;
    always #25 core_clk = ~core_clk;
    clrdec_exec u_dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .progAddr(progAddr), .progData(progData));
    clrdec_progmem u_mem (.progAddr(progAddr), .progData(progData));
    // single word transfer; no wait count assumed, the ceiling cuts a hang
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rdData = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0);
        `CHK(nm, e, rdData)
    endtask
    task automatic setf(input logic [7:0] f, input logic [7:0] v);
        wr(OFS_FILE_ADDR, {24'h0, f});
        wr(OFS_FILE_DATA, {24'h0, v});
    endtask
    task automatic chkf(input logic [7:0] f, input logic [7:0] e, input string nm);
        wr(OFS_FILE_ADDR, {24'h0, f});
        rdchk(OFS_FILE_DATA, {24'h0, e}, nm);
    endtask
    // parks the core after n instruction cycles of four clocks
    task automatic run(input logic [PC_W-1:0] pc, input int n);
        wr(OFS_PC, {19'h0, pc});
        wr(OFS_CTRL, 32'h1);
        repeat (n * 4) @(posedge core_clk);
        wr(OFS_CTRL, 32'h0);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic t_reset();
        rdchk(OFS_STATUS, 32'h6, "status");
        rdchk(OFS_ACC, 32'h0, "acc");
        rdchk(OFS_PC, 32'h0, "pc");
        wr(OFS_WDT_CNT, 32'hFF);
        rdchk(OFS_WDT_CNT, 32'h0, "wdt read only");
        rdchk(8'h40, 32'h0, "unmapped");
    endtask
    task automatic t_arith();
        u_mem.mem[13'h010] = 14'h0323;
        u_mem.mem[13'h011] = 14'h09A2;
        u_mem.mem[13'h012] = 14'h03A4;
        u_mem.mem[13'h013] = 14'h0921;
        setf(8'h21, 8'h13);
        setf(8'h22, 8'hFF);
        setf(8'h23, 8'h01);
        setf(8'h24, 8'h80);
        run(13'h010, 6);
        rdchk(OFS_ACC, 32'hEC, "comp to acc");
        chkf(8'h22, 8'h00, "comp to file");
        chkf(8'h24, 8'h7F, "dec to file");
        chkf(8'h23, 8'h01, "dec source");
        rdchk(OFS_STATUS, 32'h6, "null cleared");
    endtask
    task automatic t_kick();
        logic [31:0] c;
        run(13'h100, 300);
        xfer(OFS_WDT_CNT, 1'b0, 32'h0);
        c = rdData;
        xfer(OFS_WDT_PRE, 1'b0, 32'h0);
        `CHK("wdt counting", 1'b1, (c | rdData) != 32'h0)
        wr(OFS_STATUS, 32'h0);
        wr(OFS_ACC, 32'h33);
        u_mem.mem[13'h030] = 14'h017F;
        u_mem.mem[13'h031] = OPC_KICK_VAL;
        run(13'h030, 3);
        rdchk(OFS_ACC, 32'h0, "clear acc");
        rdchk(OFS_STATUS, 32'h7, "kick flags");
        xfer(OFS_WDT_CNT, 1'b0, 32'h0);
        c = rdData;
        xfer(OFS_WDT_PRE, 1'b0, 32'h0);
        // the idle word after the kick counts once more
        `CHK("wdt count cleared", 32'h0, c)
        `CHK("wdt prescale cleared", 32'h1, rdData)
    endtask
    task automatic t_skip();
        setf(8'h25, 8'h01);
        setf(8'h26, 8'h55);
        setf(8'h27, 8'h03);
        setf(8'h28, 8'hFF);
        wr(OFS_STATUS, 32'h0);
        wr(OFS_ACC, 32'h77);
        u_mem.mem[13'h040] = 14'h09A8;
        u_mem.mem[13'h041] = 14'h0BA7;
        u_mem.mem[13'h042] = 14'h0B25;
        u_mem.mem[13'h043] = 14'h09A6;
        run(13'h040, 6);
        rdchk(OFS_STATUS, 32'h1, "skip keeps flag");
        rdchk(OFS_ACC, 32'h0, "skip to acc");
        chkf(8'h27, 8'h02, "skip to file");
        chkf(8'h26, 8'h55, "skipped word");
        chkf(8'h25, 8'h01, "skip source");
    endtask
    task automatic t_jump();
        logic [7:0]      pcu;
        logic [7:0]      f;
        logic [PC_W-1:0] tgt;
        for (int i = 0; i < 2; i++) begin
            pcu = (i == 0) ? 8'h18 : 8'hE7;
            tgt = (i == 0) ? 13'h1923 : 13'h0123;
            f = (i == 0) ? 8'h29 : 8'h2B;
            u_mem.mem[tgt] = 14'h0980 | {6'h0, f};
            u_mem.mem[13'h050] = 14'h2923;
            u_mem.mem[13'h051] = 14'h09AA;
            setf(f, 8'h0F);
            setf(8'h2A, 8'h0F);
            wr(OFS_PCU, {24'h0, pcu});
            rdchk(OFS_PCU, {24'h0, pcu}, "latch");
            run(13'h050, 5);
            chkf(f, 8'hF0, "jump target");
            chkf(8'h2A, 8'h0F, "after jump");
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ceiling well above the roughly 1600 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_arith();
        t_kick();
        t_skip();
        t_jump();
        stop_test();
    end
endmodule

/* test/clrdec_exec_assertions.sv */
/*
 * Port checker for the exec block: fetch timing, jump targets, bus answers.
 * Assumes PHASE_DIV of 1 and no jump word right after a taken skip.
 */
`timescale 1ns/100ps
module clrdec_exec_assertions (
    input wire logic                          core_clk,
    input wire logic                          rst_b,
    input wire logic                          hsel,
    input wire logic [31:0]                   haddr,
    input wire logic [1:0]                    htrans,
    input wire logic                          hwrite,
    input wire logic [2:0]                    hsize,
    input wire logic [31:0]                   hwdata,
    input wire logic                          hready,
    input wire logic [31:0]                   hrdata,
    input wire logic                          hreadyout,
    input wire logic                          hresp,
    input wire logic [clrdec_pkg::PC_W-1:0]   progAddr,
    input wire logic [clrdec_pkg::INSTR_W-1:0] progData
);
    import clrdec_pkg::*;
    logic [PC_W-1:0]    prevAddr;
    logic [INSTR_W-1:0] prevWord;
    logic               pcuPend;
    logic [DATA_W-1:0]  pcuCopy;
    // a fetch shows as a one-step advance of the address
    wire logic fetchEv = progAddr == prevAddr + 1'b1;
    wire logic jumpEv  = fetchEv && ((prevWord & OPC_JUMP_MASK) == OPC_JUMP_VAL);
    // shadow of the fetch bus and of bus writes to the upper latch
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prevAddr <= PC_RST;
            prevWord <= OPC_IDLE_WORD;
            pcuPend <= 1'b0;
            pcuCopy <= PCU_RST;
        end else begin
            prevAddr <= progAddr;
            prevWord <= progData;
            pcuPend <= hsel && hready && htrans[1] && hwrite && haddr == {24'h0, OFS_PCU};
            if (pcuPend) begin
                pcuCopy <= hwdata[DATA_W-1:0];
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_land;
        ##3 (progAddr[JUMP_K_W-1:0] == $past(prevWord[JUMP_K_W-1:0], 3));
    endsequence
    sequence s_landHigh;
        ##3 (progAddr[PC_W-1:JUMP_K_W] == $past(pcuCopy[PCU_HI_BIT:PCU_LO_BIT], 3));
    endsequence
    sequence s_idleTail;
        $stable(progAddr)[*4] ##1 (progAddr == $past(progAddr) + 1'b1);
    endsequence
    a_jump_low: assert property (jumpEv |-> s_land)
        else $error("jump did not load the immediate field");
    a_jump_high: assert property (jumpEv |-> s_landHigh)
        else $error("jump upper bits differ from the latch");
    a_jump_idle: assert property (jumpEv |-> ##4 s_idleTail)
        else $error("second jump cycle was not idle");
    a_step_hold: assert property (fetchEv && !jumpEv |-> ##1 $stable(progAddr)[*3])
        else $error("fetch address moved inside an instruction cycle");
    a_no_wait: assert property (hsel && htrans[1] |-> hreadyout ##1 hreadyout)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (hsel && htrans[1] |-> ##1 !hresp)
        else $error("slave answered with an error");
    a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    a_reset_pc: assert property ($rose(rst_b) |-> progAddr == PC_RST)
        else $error("fetch address not at reset value");
endmodule
bind clrdec_exec clrdec_exec_assertions u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .progAddr(progAddr), .progData(progData)
);

/* test/clrdec_progmem.sv */
/*
 * Program memory model: one word per address, idle words by default.
 * Assumes the bench preloads words into mem while the core is parked.
 */
`timescale 1ns/100ps
module clrdec_progmem (
    input  wire logic [clrdec_pkg::PC_W-1:0]    progAddr,
    output logic      [clrdec_pkg::INSTR_W-1:0] progData
);
    import clrdec_pkg::*;
    logic [INSTR_W-1:0] mem [2**PC_W];
    // combinational answer, the core samples in the same cycle
    assign progData = mem[progAddr];
    initial begin
        foreach (mem[i]) begin
            mem[i] = OPC_IDLE_WORD;
        end
    end
endmodule
